// File: lpcg_ctrl.sv
// Notes on behaviour
// - Bit 24 set clocks CAN unit
// - Bit 20 set clocks PWM unit
// - Bit 3 set clocks watchdog unit
// - Access to gated unit returns bus fault
// - Gating bits reset to zero, units unclocked
// - Deep-sleep register resets 0x40, bit 6 fixed
// - Deep-sleep register decodes at offset 0x120
// - Run, sleep, deep register chosen by mode
// - Sleep registers apply only with auto-gating set
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lpcg_map.svh"

module lpcg_ctrl
  import lpcg_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Avalon-MM slave
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic [1:0] avs_response_o,
  output logic avs_waitrequest_o,
  // Power mode from the power manager
  input wire logic [1:0] pwr_mode_i,
  // Clock enables for the governed units
  output logic can_clk_en_o,
  output logic pwm_clk_en_o,
  output logic wdt_clk_en_o,
  // Peripheral bus requests forwarded when the target is clocked
  output logic periph_read_o,
  output logic periph_write_o,
  output logic [11:0] periph_address_o,
  output logic [31:0] periph_writedata_o,
  input wire logic [31:0] periph_readdata_i
);

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  lpcg_req_s req;
  logic access;
  logic [1:0] unit_sel;
  logic hit_run;
  logic hit_sleep;
  logic hit_deep;
  logic hit_cfg;
  logic hit_mode;
  logic hit_fault;
  logic unit_clocked;
  logic unit_fault;

  // Request fields travel together as one struct
  assign req = '{read: avs_read_i, write: avs_write_i, address: avs_address_i,
                 byteenable: avs_byteenable_i, writedata: avs_writedata_i};
  assign access = req.read | req.write;
  assign unit_sel = req.address[11:10];
  // Full-address compares; a partial decode would alias registers across the window
  assign hit_run = (req.address == `LPCG_OFF_RUN_GATE);
  assign hit_sleep = (req.address == `LPCG_OFF_SLEEP_GATE);
  assign hit_deep = (req.address == `LPCG_OFF_DEEP_GATE);
  assign hit_cfg = (req.address == `LPCG_OFF_RUN_CFG);
  assign hit_mode = (req.address == `LPCG_OFF_PWR_MODE);
  assign hit_fault = (req.address == `LPCG_OFF_FAULT);

  ////////////////////////////////////////////////////////////////////////////
  // Register bank: one answer cycle, so waitrequest drops on cycle 1

  logic busy_ff;
  logic nxt_busy;
  logic wr_take;
  logic [31:0] run_gate;
  logic [31:0] sleep_gate;
  logic [31:0] deep_gate;
  logic [31:0] run_cfg;

  // First cycle of a request stalls, second completes it
  always_comb begin
    nxt_busy = access & ~busy_ff;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
    end
  end

  // Writes land only in the answer cycle, one edge after the stall
  assign avs_waitrequest_o = access & ~busy_ff;
  assign wr_take = req.write & busy_ff & (unit_sel == 2'h0);

  // Run-mode gating register
  lpcg_gate_reg #(.WMASK(`LPCG_GATE_WMASK), .RESET(`LPCG_GATE_RESET)) u_run_gate (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .wr_i(wr_take & hit_run),
    .be_i(req.byteenable),
    .wdata_i(req.writedata),
    .value_o(run_gate)
  );

  // Sleep-mode gating register
  lpcg_gate_reg #(.WMASK(`LPCG_GATE_WMASK), .RESET(`LPCG_GATE_RESET)) u_sleep_gate (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .wr_i(wr_take & hit_sleep),
    .be_i(req.byteenable),
    .wdata_i(req.writedata),
    .value_o(sleep_gate)
  );

  // Deep-sleep gating register
  lpcg_gate_reg #(.WMASK(`LPCG_GATE_WMASK), .RESET(`LPCG_GATE_RESET)) u_deep_gate (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .wr_i(wr_take & hit_deep),
    .be_i(req.byteenable),
    .wdata_i(req.writedata),
    .value_o(deep_gate)
  );

  // Run configuration register, only the auto-gating select is writable
  lpcg_gate_reg #(.WMASK(`LPCG_CFG_WMASK), .RESET(`LPCG_CFG_RESET)) u_run_cfg (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .wr_i(wr_take & hit_cfg),
    .be_i(req.byteenable),
    .wdata_i(req.writedata),
    .value_o(run_cfg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Gating selection by power mode

  logic auto_gating_select;
  lpcg_mode_e mode;
  logic [31:0] active_gate;
  lpcg_gate_s gate_ff;
  lpcg_gate_s nxt_gate;

  // Auto-gating select lives in the run configuration register
  assign auto_gating_select = run_cfg[`LPCG_BIT_AUTO_GATE];
  assign mode = lpcg_mode_e'(pwr_mode_i);

  // Without auto-gating the run register rules every mode
  always_comb begin
    active_gate = run_gate;
    if (auto_gating_select) begin
      unique case (mode)
        LPCG_MODE_RUN: active_gate = run_gate;
        LPCG_MODE_SLEEP: active_gate = sleep_gate;
        LPCG_MODE_DEEP: active_gate = deep_gate;
        default: active_gate = run_gate; // Illegal mode code falls back to run
      endcase
    end
    nxt_gate.can = active_gate[`LPCG_BIT_CAN];
    nxt_gate.pwm = active_gate[`LPCG_BIT_PWM];
    nxt_gate.wdt = active_gate[`LPCG_BIT_WDT];
  end

  // Registered enables avoid glitches into the downstream clock gates
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gate_ff <= '0;
    end else begin
      gate_ff <= nxt_gate;
    end
  end

  // One enable per governed unit
  assign can_clk_en_o = gate_ff.can;
  assign pwm_clk_en_o = gate_ff.pwm;
  assign wdt_clk_en_o = gate_ff.wdt;

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral forwarding and bus-fault answer

  logic [31:0] fault_cnt_ff;
  logic [31:0] nxt_fault_cnt;
  logic [11:0] fwd_addr_ff;
  logic [11:0] nxt_fwd_addr;
  logic [31:0] fwd_wdata_ff;
  logic [31:0] nxt_fwd_wdata;

  // Local window always answers; unit windows follow their enable
  always_comb begin
    unique case (unit_sel)
      `LPCG_SEL_CAN: unit_clocked = gate_ff.can;
      `LPCG_SEL_PWM: unit_clocked = gate_ff.pwm;
      `LPCG_SEL_WDT: unit_clocked = gate_ff.wdt;
      2'h0: unit_clocked = 1'b1; // Local registers are never gated
    endcase
  end

  // A gated unit never sees the strobe, so it cannot be half-written
  assign unit_fault = (unit_sel != 2'h0) & ~unit_clocked;
  assign periph_read_o = req.read & busy_ff & (unit_sel != 2'h0) & unit_clocked;
  assign periph_write_o = req.write & busy_ff & (unit_sel != 2'h0) & unit_clocked;
  assign periph_address_o = fwd_addr_ff;
  assign periph_writedata_o = fwd_wdata_ff;

  // Address and data are captured in the stall cycle and held until the next request,
  // so a peripheral sees them steady from a flop while its strobe is high
  always_comb begin
    nxt_fwd_addr = fwd_addr_ff;
    nxt_fwd_wdata = fwd_wdata_ff;
    if (access & ~busy_ff) begin
      nxt_fwd_addr = req.address;
      nxt_fwd_wdata = req.writedata;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fwd_addr_ff <= 12'h000;
      fwd_wdata_ff <= 32'h0000_0000;
    end else begin
      fwd_addr_ff <= nxt_fwd_addr;
      fwd_wdata_ff <= nxt_fwd_wdata;
    end
  end

  // Counts faulted accesses so software can see the gating at work
  always_comb begin
    nxt_fault_cnt = fault_cnt_ff;
    if (access & busy_ff & unit_fault) begin
      nxt_fault_cnt = fault_cnt_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_cnt_ff <= 32'h0000_0000;
    end else begin
      fault_cnt_ff <= nxt_fault_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and response, valid while waitrequest is low

  logic local_hit;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  assign local_hit = hit_run | hit_sleep | hit_deep | hit_cfg | hit_mode | hit_fault;

  // Local readback is taken in the stall cycle; nothing local can change before the answer
  always_comb begin
    nxt_rdata = rdata_ff;
    if (req.read & ~busy_ff) begin
      nxt_rdata = 32'h0000_0000;
      if (hit_run) begin
        nxt_rdata = run_gate;
      end else if (hit_sleep) begin
        nxt_rdata = sleep_gate;
      end else if (hit_deep) begin
        nxt_rdata = deep_gate;
      end else if (hit_cfg) begin
        nxt_rdata = run_cfg;
      end else if (hit_mode) begin
        nxt_rdata = {29'h0000_0000, auto_gating_select, pwr_mode_i};
      end else if (hit_fault) begin
        nxt_rdata = fault_cnt_ff;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Peripheral data passes straight through, a gated unit answers with an error
  always_comb begin
    avs_readdata_o = rdata_ff;
    avs_response_o = 2'h0;
    if (unit_sel != 2'h0) begin
      if (unit_fault) begin
        avs_readdata_o = 32'h0000_0000;
        avs_response_o = 2'h2; // SLVERR
      end else begin
        avs_readdata_o = periph_readdata_i;
      end
    end else if (!local_hit) begin
      avs_response_o = 2'h3; // DECODEERROR for unmapped offsets
    end
  end

endmodule : lpcg_ctrl

`default_nettype wire

// File: lpcg_map.svh
`ifndef LPCG_MAP_SVH
`define LPCG_MAP_SVH

// Register byte offsets within the system control space
`define LPCG_OFF_RUN_GATE 12'h100
`define LPCG_OFF_SLEEP_GATE 12'h110
`define LPCG_OFF_DEEP_GATE 12'h120
`define LPCG_OFF_RUN_CFG 12'h060
`define LPCG_OFF_PWR_MODE 12'h130
`define LPCG_OFF_FAULT 12'h134

// Gating field positions
`define LPCG_BIT_CAN 24
`define LPCG_BIT_PWM 20
`define LPCG_BIT_WDT 3
`define LPCG_BIT_FIXED_ONE 6
`define LPCG_BIT_AUTO_GATE 27

// Writable bits and reset values of the gating registers
`define LPCG_GATE_WMASK 32'h0110_0008
`define LPCG_GATE_RESET 32'h0000_0040
`define LPCG_CFG_WMASK 32'h0800_0000
`define LPCG_CFG_RESET 32'h0000_0000

// Peripheral windows: address bits [11:10] pick the unit, 2'b00 is this block
`define LPCG_SEL_CAN 2'h1
`define LPCG_SEL_PWM 2'h2
`define LPCG_SEL_WDT 2'h3

`endif

// File: lpcg_pkg.sv
package lpcg_pkg;

  typedef enum logic [1:0] {
    LPCG_MODE_RUN = 2'b00,
    LPCG_MODE_SLEEP = 2'b01,
    LPCG_MODE_DEEP = 2'b10
  } lpcg_mode_e;

  // Avalon-MM request as seen by the slave
  typedef struct packed {
    logic read;
    logic write;
    logic [11:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } lpcg_req_s;

  // Clock enables of the governed units
  typedef struct packed {
    logic can;
    logic pwm;
    logic wdt;
  } lpcg_gate_s;

endpackage : lpcg_pkg

// File: lpcg_gate_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpcg_map.svh"

// One 32-bit gating or configuration register with byte enables and fixed bits
module lpcg_gate_reg
  import lpcg_pkg::*;
#(
  parameter logic [31:0] WMASK = `LPCG_GATE_WMASK,
  parameter logic [31:0] RESET = `LPCG_GATE_RESET
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic wr_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] value_o
);

  logic [31:0] val_ff;
  logic [31:0] nxt_val;
  logic [31:0] lane_mask;

  // Only writable bits in enabled lanes change; fixed bits keep reset value
  always_comb begin
    lane_mask = {{8{be_i[3]}}, {8{be_i[2]}}, {8{be_i[1]}}, {8{be_i[0]}}};
    nxt_val = val_ff;
    if (wr_i) begin
      nxt_val = (val_ff & ~(WMASK & lane_mask)) | (wdata_i & WMASK & lane_mask);
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      val_ff <= RESET;
    end else begin
      val_ff <= nxt_val;
    end
  end

  assign value_o = val_ff;

endmodule : lpcg_gate_reg

`default_nettype wire

// File: lpcg_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpcg_map.svh"
module lpcg_ctrl_checker
  import lpcg_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic [1:0] avs_response_o,
  input wire logic avs_waitrequest_o,
  input wire logic [1:0] pwr_mode_i,
  input wire logic can_clk_en_o,
  input wire logic pwm_clk_en_o,
  input wire logic wdt_clk_en_o,
  input wire logic periph_read_o,
  input wire logic periph_write_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  wire logic req = avs_read_i | avs_write_i;
  wire logic fin = req & ~avs_waitrequest_o;
  wire logic [1:0] sel = avs_address_i[11:10];
  wire logic on = (sel == 2'h1) ? can_clk_en_o : (sel == 2'h2) ? pwm_clk_en_o : wdt_clk_en_o;
  //////////////////////////////////////////
  // Cycles since the last write or mode change; enables may only move shortly after one
  logic [1:0] quiet_ff, nxt_quiet, mode_ff;
  always_comb begin
    nxt_quiet = (quiet_ff == 2'h3) ? 2'h3 : quiet_ff + 2'h1;
    if ((fin & avs_write_i) | (pwr_mode_i != mode_ff)) nxt_quiet = 2'h0;
  end
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      quiet_ff <= 2'h0;
      mode_ff <= 2'h0;
    end else begin
      quiet_ff <= nxt_quiet;
      mode_ff <= pwr_mode_i;
    end
  end
  //////////////////////////////////////////
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest_o)
    else $error("no wait cycle at request start");
  a_wait_bound: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("wait cycle too long");
  a_fault_resp: assert property (fin && sel != 2'h0 && !on |-> avs_response_o == 2'b10
    && !periph_read_o && !periph_write_o) else $error("gated unit not faulted");
  a_fwd_ok: assert property (fin && sel != 2'h0 && on |-> avs_response_o == 2'b00
    && periph_read_o == avs_read_i && periph_write_o == avs_write_i) else $error("bad forward");
  a_fwd_only: assert property (periph_read_o || periph_write_o |-> fin && on)
    else $error("stray forward");
  a_ro_bits: assert property (fin && avs_read_i && avs_address_i inside {12'h100, 12'h110,
    12'h120} |-> (avs_readdata_o & ~`LPCG_GATE_WMASK) == `LPCG_GATE_RESET)
    else $error("fixed bits wrong");
  a_reset_off: assert property (disable iff (1'b0) !arst_n_i |->
    !can_clk_en_o && !pwm_clk_en_o && !wdt_clk_en_o) else $error("enable on in reset");
  a_en_stable: assert property (quiet_ff == 2'h3 |->
    $stable({can_clk_en_o, pwm_clk_en_o, wdt_clk_en_o})) else $error("enable moved alone");
endmodule : lpcg_ctrl_checker
bind lpcg_ctrl lpcg_ctrl_checker i_chk (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_response_o(avs_response_o),
  .avs_waitrequest_o(avs_waitrequest_o), .pwr_mode_i(pwr_mode_i),
  .can_clk_en_o(can_clk_en_o), .pwm_clk_en_o(pwm_clk_en_o), .wdt_clk_en_o(wdt_clk_en_o),
  .periph_read_o(periph_read_o), .periph_write_o(periph_write_o));
`default_nettype wire

// File: lpcg_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpcg_map.svh"
module lpcg_ctrl_test
  import lpcg_pkg::*;
;
  logic clk, arst_n, rd, wr, wait_r, pr, pw, can_en, pwm_en, wdt_en;
  logic [11:0] addr, pa;
  logic [3:0] be;
  logic [31:0] wd, rdata, prd, pwd, q;
  logic [1:0] resp, mode, r, fwd;
  int err_count, checks_done;
  int pos [3] = '{`LPCG_BIT_CAN, `LPCG_BIT_PWM, `LPCG_BIT_WDT};
  logic [11:0] offs [3] = '{`LPCG_OFF_RUN_GATE, `LPCG_OFF_SLEEP_GATE, `LPCG_OFF_DEEP_GATE};
  lpcg_ctrl i_dut (.core_clk_i(clk), .arst_n_i(arst_n), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be), .avs_writedata_i(wd),
    .avs_readdata_o(rdata), .avs_response_o(resp), .avs_waitrequest_o(wait_r),
    .pwr_mode_i(mode), .can_clk_en_o(can_en), .pwm_clk_en_o(pwm_en), .wdt_clk_en_o(wdt_en),
    .periph_read_o(pr), .periph_write_o(pw), .periph_address_o(pa),
    .periph_writedata_o(pwd), .periph_readdata_i(prd));
  //////////////////////////////////////////
  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Request held until waitrequest is seen low at a rising edge, released only after it
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= d;
    be <= b;
    do begin
      @(posedge clk);
    end while (wait_r !== 1'b0);
    q = rdata;
    r = resp;
    fwd = {pr, pw};
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : xfer
  // Enables settle one edge after the register or mode change
  task automatic gates(input logic [2:0] e);
    repeat (2) @(posedge clk);
    chk({29'h0, can_en, pwm_en, wdt_en}, {29'h0, e});
  endtask : gates
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  //////////////////////////////////////////
  // Main sequence
  initial begin
    {arst_n, rd, wr, addr, wd, be, mode, err_count, checks_done} = '0;
    prd = 32'hA5A5_0001;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    gates(3'b000);
    foreach (offs[i]) begin
      xfer(1'b0, offs[i], 32'h0, 4'hF);
      chk(q, `LPCG_GATE_RESET);
    end
    $display("reset values done");
    for (int i = 1; i < 4; i++) begin
      xfer(i[0], {i[1:0], 10'h010}, 32'h5, 4'hF);
      chk({30'h0, r}, 32'h2);
      chk({30'h0, fwd}, 32'h0);
    end
    xfer(1'b0, `LPCG_OFF_FAULT, 32'h0, 4'hF);
    chk(q, 32'h3);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, `LPCG_OFF_RUN_GATE, 32'h1 << pos[i], 4'hF);
      xfer(1'b0, `LPCG_OFF_RUN_GATE, 32'h0, 4'hF);
      chk(q, 32'h40 | (32'h1 << pos[i]));
      gates(3'b100 >> i);
    end
    xfer(1'b1, `LPCG_OFF_RUN_GATE, 32'hFFFF_FFFF, 4'hF);
    xfer(1'b0, `LPCG_OFF_RUN_GATE, 32'h0, 4'hF);
    chk(q, 32'h0110_0048);
    gates(3'b111);
    xfer(1'b0, 12'h404, 32'h0, 4'hF);
    chk({30'h0, r}, 32'h0);
    chk(q, 32'hA5A5_0001);
    chk({30'h0, fwd}, 32'h2);
    chk({20'h0, pa}, 32'h404);
    xfer(1'b1, 12'h408, 32'h1234_5678, 4'hF);
    chk({30'h0, fwd}, 32'h1);
    chk(pwd, 32'h1234_5678);
    $display("run gating done");
    xfer(1'b1, `LPCG_OFF_DEEP_GATE, 32'h0010_0000, 4'hF);
    xfer(1'b1, `LPCG_OFF_SLEEP_GATE, 32'h0100_0000, 4'hF);
    mode <= LPCG_MODE_DEEP;
    gates(3'b111);
    xfer(1'b1, `LPCG_OFF_RUN_CFG, 32'h0800_0000, 4'hF);
    gates(3'b010);
    mode <= LPCG_MODE_SLEEP;
    gates(3'b100);
    xfer(1'b0, `LPCG_OFF_PWR_MODE, 32'h0, 4'hF);
    chk(q, 32'h5);
    mode <= 2'b11;
    gates(3'b111);
    mode <= LPCG_MODE_DEEP;
    xfer(1'b1, `LPCG_OFF_DEEP_GATE, 32'hFFFF_FFFF, 4'b1000);
    xfer(1'b0, `LPCG_OFF_DEEP_GATE, 32'h0, 4'hF);
    chk(q, 32'h0110_0040);
    gates(3'b110);
    xfer(1'b0, 12'hC00, 32'h0, 4'hF);
    chk({30'h0, r}, 32'h2);
    xfer(1'b0, 12'h124, 32'h0, 4'hF);
    chk({30'h0, r}, 32'h3);
    xfer(1'b0, `LPCG_OFF_FAULT, 32'h0, 4'hF);
    chk(q, 32'h4);
    $display("sleep gating done");
    @(posedge clk);
    arst_n <= 1'b0;
    gates(3'b000);
    arst_n <= 1'b1;
    xfer(1'b0, `LPCG_OFF_DEEP_GATE, 32'h0, 4'hF);
    chk(q, `LPCG_GATE_RESET);
    xfer(1'b1, `LPCG_OFF_DEEP_GATE, q | 32'h8, 4'hF);
    xfer(1'b0, `LPCG_OFF_DEEP_GATE, 32'h0, 4'hF);
    chk(q, 32'h48);
    xfer(1'b0, `LPCG_OFF_FAULT, 32'h0, 4'hF);
    chk(q, 32'h0);
    xfer(1'b0, `LPCG_OFF_RUN_CFG, 32'h0, 4'hF);
    chk(q, 32'h0);
    $display("second reset done");
    wrap_up();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end
endmodule : lpcg_ctrl_test
`default_nettype wire
